// [hdl/odurc_pkg.sv]
// Behaviour
// R1: Readback command latches address as read channel.
// R2: Next frame shifts selected register out SDO.
// R3: Readback frame enables SDO even when unchained.
// R4: First eight bits undefined, last sixteen value.
// R5: Host sends no-operation frame to collect data.
// R6: SDO weakly holds last bit while select high.
// R7: Power command: channel n uses bits 2n+1:2n.
// R8: Field 00 normal, 01 ground load, 11 three-state.
// R9: Host zeroes bit 19 in power frames.
// R10: Power-down keeps and still updates DAC registers.
// R11: Write input with strobe low updates both.
// R12: Strobe high: input only, DAC on strobe fall.
// R13: 0010 copies input to DAC; 0011 writes both.
// R14: Mask command loads eight mask bits, reset zero.
// R15: Masked channel ignores load strobe transitions.
// R16: Strobe falling edge loads unmasked DAC registers.
// R17: Strobe held low disregards the mask.
// R18: Clear forces selected code, held after release.
// R19: No output updates while clear is low.
// R20: Ignore pins during power-on; wait clear release.
// R21: Frame select low; SDI shifted on SCLK fall.
// R22: Command executes at frame select rising edge.
// R23: Chain command sets chain enable from bit 0.
// R24: Clear loads code into input and DAC registers.
// R25: Reset: power normal, readback selection cleared.
package odurc_pkg;
  localparam int NCH = 8;
  localparam int DW  = 16;
  localparam int FW  = 24;
  localparam int CMD_MSB  = 23;
  localparam int CMD_LSB  = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_WR_IN      = 4'h1;
  localparam logic [3:0] CMD_UPD        = 4'h2;
  localparam logic [3:0] CMD_WR_UPD     = 4'h3;
  localparam logic [3:0] CMD_PWR        = 4'h4;
  localparam logic [3:0] CMD_MASK       = 4'h5;
  localparam logic [3:0] CMD_CHAIN      = 4'h8;
  localparam logic [3:0] CMD_READ       = 4'h9;
  localparam logic [3:0] CMD_WR_IN_ALL  = 4'hA;
  localparam logic [3:0] CMD_WR_UPD_ALL = 4'hB;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_GND    = 2'h1;
  localparam logic [1:0] PWR_TRI    = 2'h3;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic        CHAIN_RST = 1'b0;
  localparam logic [2:0]  RBSEL_RST = 3'h0;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;
  localparam logic [4:0]  LINK_CNT_MAX = 5'h1F;
  localparam logic [4:0]  LINK_LAST    = 5'h17;
  localparam logic [4:0]  LINK_BITS    = 5'h18;
  typedef enum logic {ODURC_INIT, ODURC_RUN} odurc_state_t;
endpackage

// [hdl/odurc_link.sv]
`timescale 1ns/1ps
`default_nettype none
module odurc_link (
  // Link pins
  input  wire logic                          i_sclk,
  input  wire logic                          i_rst,
  input  wire logic                          i_sync_n,
  input  wire logic                          i_sdi,
  // From the system side, quasi-static during a frame
  input  wire logic [odurc_pkg::FW-1:0]      i_tx_word,
  input  wire logic                          i_readback,
  input  wire logic                          i_chain_enable,
  // Received frame and serial output
  output logic      [odurc_pkg::FW-1:0]      o_frame_word,
  output logic                               o_sdo,
  output logic                               o_sdo_oe,
  output logic                               o_sdo_keep
);
  logic [4:0]               cnt_r;
  logic [4:0]               cnt_nxt;
  logic [odurc_pkg::FW-1:0] shift_nxt;
  logic                     sdo_nxt;
  logic [4:0]               idx;

  always_comb begin
    cnt_nxt   = (cnt_r == odurc_pkg::LINK_CNT_MAX) ? cnt_r : cnt_r + 5'h01;
    shift_nxt = {o_frame_word[odurc_pkg::FW-2:0], i_sdi}; // see R21
    idx       = odurc_pkg::LINK_LAST - cnt_r;
    sdo_nxt   = o_sdo;
    if (i_readback) begin
      if (cnt_r < odurc_pkg::LINK_BITS) begin
        sdo_nxt = i_tx_word[idx]; // see R2
      end
    end else begin
      sdo_nxt = o_frame_word[odurc_pkg::FW-1];
    end
  end

  // The select pin ends the count so nothing waits on an SCLK edge after the frame
  always_ff @(negedge i_sclk or posedge i_rst or posedge i_sync_n) begin
    if (i_rst || i_sync_n) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(negedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_word <= 24'h000000;
    end else begin
      o_frame_word <= shift_nxt;
    end
  end

  // Data leaves on the rising edge so it is valid at the host's falling edge
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      o_sdo <= 1'b0;
    end else begin
      o_sdo <= sdo_nxt;
    end
  end

  assign o_sdo_oe   = ~i_sync_n & (i_readback | i_chain_enable); // see R3
  assign o_sdo_keep = ~o_sdo_oe; // see R6
endmodule
`default_nettype wire

// [hdl/odurc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module odurc_top (
  // System
  input  wire logic                                         i_clk,
  input  wire logic                                         i_sys_rst,
  // Serial link
  input  wire logic                                         i_sclk,
  input  wire logic                                         i_sync_n,
  input  wire logic                                         i_sdi,
  output logic                                              o_sdo,
  output logic                                              o_sdo_oe,
  output logic                                              o_sdo_keep,
  // Control pins
  input  wire logic                                         i_load_strobe_n,
  input  wire logic                                         i_clear_n,
  input  wire logic                                         i_clear_level_select,
  // Converter state
  output logic      [odurc_pkg::NCH-1:0][odurc_pkg::DW-1:0] o_dac_code,
  output logic      [odurc_pkg::NCH-1:0][odurc_pkg::DW-1:0] o_input_code,
  output logic      [odurc_pkg::NCH-1:0][1:0]               o_power_mode,
  output logic      [odurc_pkg::NCH-1:0]                    o_update_mask,
  output logic                                              o_chain_enable,
  output logic                                              o_init_done
);
  localparam int NCH = odurc_pkg::NCH;
  localparam int DW  = odurc_pkg::DW;
  localparam int FW  = odurc_pkg::FW;

  // Pin synchronisers: bit 3 select, 2 strobe, 1 clear, 0 level select
  logic [3:0] meta_r;
  logic [3:0] pin_r;
  logic       sync_s;
  logic       load_s;
  logic       clear_s;
  logic       level_s;
  logic       sync_prev_r;
  logic       load_prev_r;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Clear starts asserted so start-up waits for the real pin level
      meta_r      <= 4'hC;
      pin_r       <= 4'hC;
      sync_prev_r <= 1'b1;
      load_prev_r <= 1'b1;
    end else begin
      meta_r      <= {i_sync_n, i_load_strobe_n, i_clear_n, i_clear_level_select};
      pin_r       <= meta_r;
      sync_prev_r <= sync_s;
      load_prev_r <= load_s;
    end
  end

  assign sync_s  = pin_r[3];
  assign load_s  = pin_r[2];
  assign clear_s = pin_r[1];
  assign level_s = pin_r[0];

  // Control state
  odurc_pkg::odurc_state_t           st_r;
  odurc_pkg::odurc_state_t           st_nxt;
  logic [NCH-1:0][DW-1:0]            in_r;
  logic [NCH-1:0][DW-1:0]            in_nxt;
  logic [NCH-1:0][DW-1:0]            dac_r;
  logic [NCH-1:0][DW-1:0]            dac_nxt;
  logic [NCH-1:0][1:0]               pwr_r;
  logic [NCH-1:0][1:0]               pwr_nxt;
  logic [NCH-1:0]                    mask_r;
  logic [NCH-1:0]                    mask_nxt;
  logic                              chain_r;
  logic                              chain_nxt;
  logic                              rb_arm_r;
  logic                              rb_arm_nxt;
  logic [2:0]                        rb_sel_r;
  logic [2:0]                        rb_sel_nxt;
  logic [FW-1:0]                     rb_word_r;
  logic [FW-1:0]                     rb_word_nxt;

  // Frame decode
  logic [FW-1:0]                     word;
  logic [3:0]                        cmd;
  logic [3:0]                        addr;
  logic [DW-1:0]                     data;
  logic [DW-1:0]                     clr_code;
  logic                              frame_done;
  logic                              strobe_fall;
  logic                              running;

  assign cmd         = word[odurc_pkg::CMD_MSB:odurc_pkg::CMD_LSB];
  assign addr        = word[odurc_pkg::ADDR_MSB:odurc_pkg::ADDR_LSB];
  assign data        = word[odurc_pkg::DATA_MSB:0];
  assign clr_code    = level_s ? odurc_pkg::CODE_MID : odurc_pkg::CODE_ZERO;
  assign running     = (st_r == odurc_pkg::ODURC_RUN);
  // The shift register is idle once select is high, so it is safe to sample here
  assign frame_done  = running & sync_s & ~sync_prev_r; // see R22
  assign strobe_fall = running & ~load_s & load_prev_r; // see R20

  always_comb begin
    st_nxt      = st_r;
    in_nxt      = in_r;
    dac_nxt     = dac_r;
    pwr_nxt     = pwr_r;
    mask_nxt    = mask_r;
    chain_nxt   = chain_r;
    rb_arm_nxt  = rb_arm_r;
    rb_sel_nxt  = rb_sel_r;
    // Snapshot only between frames so a strobe mid-frame cannot tear the word
    rb_word_nxt = sync_s ? {{(FW-DW){1'b0}}, dac_r[rb_sel_r]} : rb_word_r; // see R4
    unique case (st_r)
      odurc_pkg::ODURC_INIT: begin
        for (int ch = 0; ch < NCH; ch++) begin
          in_nxt[ch]  = clr_code;
          dac_nxt[ch] = clr_code;
        end
        if (clear_s) begin
          st_nxt = odurc_pkg::ODURC_RUN; // see R20
        end
      end
      odurc_pkg::ODURC_RUN: begin
        if (frame_done) begin
          rb_arm_nxt = (cmd == odurc_pkg::CMD_READ); // see R2
          case (cmd)
            odurc_pkg::CMD_READ:  rb_sel_nxt = addr[2:0]; // see R1
            // Bits 19 to 16 are not looked at; DAC registers are left alone
            odurc_pkg::CMD_PWR:   pwr_nxt    = data; // see R7 see R8 see R10
            odurc_pkg::CMD_MASK:  mask_nxt   = data[NCH-1:0]; // see R14
            odurc_pkg::CMD_CHAIN: chain_nxt  = data[0]; // see R23
            default: ;
          endcase
        end
        if (!clear_s) begin
          for (int ch = 0; ch < NCH; ch++) begin
            in_nxt[ch]  = clr_code; // see R24
            dac_nxt[ch] = clr_code; // see R18 see R19
          end
        end else begin
          if (strobe_fall) begin
            for (int ch = 0; ch < NCH; ch++) begin
              if (!mask_r[ch]) begin
                dac_nxt[ch] = in_r[ch]; // see R15 see R16
              end
            end
          end
          if (frame_done) begin
            for (int ch = 0; ch < NCH; ch++) begin
              case (cmd)
                odurc_pkg::CMD_WR_IN: begin
                  if (addr == 4'(ch)) begin
                    in_nxt[ch] = data; // see R12
                    // A strobe held low passes the write through whatever the mask says
                    if (!load_s) begin
                      dac_nxt[ch] = data; // see R11 see R17
                    end
                  end
                end
                odurc_pkg::CMD_UPD: begin
                  if (data[ch]) begin
                    dac_nxt[ch] = in_r[ch]; // see R13
                  end
                end
                odurc_pkg::CMD_WR_UPD: begin
                  if (addr == 4'(ch)) begin
                    in_nxt[ch]  = data; // see R13
                    dac_nxt[ch] = data;
                  end
                end
                odurc_pkg::CMD_WR_IN_ALL: begin
                  in_nxt[ch] = data;
                end
                odurc_pkg::CMD_WR_UPD_ALL: begin
                  in_nxt[ch]  = data;
                  dac_nxt[ch] = data;
                end
                default: ;
              endcase
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r      <= odurc_pkg::ODURC_INIT;
      in_r      <= '0;
      dac_r     <= '0;
      pwr_r     <= '0; // see R25
      mask_r    <= odurc_pkg::MASK_RST;
      chain_r   <= odurc_pkg::CHAIN_RST;
      rb_arm_r  <= 1'b0;
      rb_sel_r  <= odurc_pkg::RBSEL_RST; // see R25
      rb_word_r <= 24'h000000;
    end else begin
      st_r      <= st_nxt;
      in_r      <= in_nxt;
      dac_r     <= dac_nxt;
      pwr_r     <= pwr_nxt;
      mask_r    <= mask_nxt;
      chain_r   <= chain_nxt;
      rb_arm_r  <= rb_arm_nxt;
      rb_sel_r  <= rb_sel_nxt;
      rb_word_r <= rb_word_nxt;
    end
  end

  // Readback word, arm and chain bit change only while select is high, and the
  // host keeps select high well beyond two system cycles, so the link side sees
  // them settled before its first SCLK edge; a stopped SCLK rules out a resync.
  odurc_link u_link (
    .i_sclk         (i_sclk),
    .i_rst          (i_sys_rst),
    .i_sync_n       (i_sync_n),
    .i_sdi          (i_sdi),
    .i_tx_word      (rb_word_r),
    .i_readback     (rb_arm_r),
    .i_chain_enable (chain_r),
    .o_frame_word   (word),
    .o_sdo          (o_sdo),
    .o_sdo_oe       (o_sdo_oe),
    .o_sdo_keep     (o_sdo_keep)
  );

  assign o_dac_code     = dac_r;
  assign o_input_code   = in_r;
  assign o_power_mode   = pwr_r;
  assign o_update_mask  = mask_r;
  assign o_chain_enable = chain_r;
  assign o_init_done    = running;

  property p_read_select;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && cmd == odurc_pkg::CMD_READ |=> rb_arm_r && rb_sel_r == $past(addr[2:0]);
  endproperty
  a_read_select: assert property (p_read_select) else $error("readback select not latched"); // see R1

  property p_read_once;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && cmd != odurc_pkg::CMD_READ |=> !rb_arm_r;
  endproperty
  a_read_once: assert property (p_read_once) else $error("readback frame not ended"); // see R2

  property p_read_word;
    @(posedge i_clk) disable iff (i_sys_rst)
      sync_s |=> rb_word_r[FW-1:DW] == 8'h00 && rb_word_r[DW-1:0] == $past(dac_r[rb_sel_r]);
  endproperty
  a_read_word: assert property (p_read_word) else $error("readback word wrong"); // see R4

  property p_oe_auto;
    @(posedge i_clk) disable iff (i_sys_rst)
      !sync_s && !chain_r && !rb_arm_r ##2 !sync_s && !chain_r && !rb_arm_r |-> !o_sdo_oe;
  endproperty
  a_oe_auto: assert property (p_oe_auto) else $error("SDO driven outside readback"); // see R3

  property p_power_fields;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && cmd == odurc_pkg::CMD_PWR |=> pwr_r == $past(data)
      && ($stable(dac_r) || $past(strobe_fall) || !$past(clear_s));
  endproperty
  a_power_fields: assert property (p_power_fields) else $error("power fields wrong"); // see R7

  property p_mask_load;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && cmd == odurc_pkg::CMD_MASK |=> mask_r == $past(data[NCH-1:0]);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded"); // see R14

  property p_strobe_blocked;
    @(posedge i_clk) disable iff (i_sys_rst)
      strobe_fall && clear_s && !frame_done && mask_r[NCH-1] |=> $stable(dac_r[NCH-1]);
  endproperty
  a_strobe_blocked: assert property (p_strobe_blocked) else $error("masked ch moved"); // see R15

  property p_strobe_load;
    @(posedge i_clk) disable iff (i_sys_rst)
      strobe_fall && clear_s && !frame_done && !mask_r[0] |=> dac_r[0] == $past(in_r[0]);
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("strobe did not load"); // see R16

  property p_write_through;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && clear_s && !load_s && cmd == odurc_pkg::CMD_WR_IN && addr == 4'h7
      |=> dac_r[NCH-1] == $past(data) && in_r[NCH-1] == $past(data);
  endproperty
  a_write_through: assert property (p_write_through) else $error("write not passed"); // see R11

  property p_write_held;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && clear_s && load_s && !load_prev_r == 1'b0 && cmd == odurc_pkg::CMD_WR_IN
      && addr == 4'h0 |=> in_r[0] == $past(data) && $stable(dac_r[0]);
  endproperty
  a_write_held: assert property (p_write_held) else $error("DAC moved on held write"); // see R12

  property p_clear_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      running && !clear_s |=> dac_r[NCH-1] == $past(clr_code) && in_r[0] == $past(clr_code);
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear did not force code"); // see R19

  property p_init_wait;
    @(posedge i_clk) disable iff (i_sys_rst)
      !running && !clear_s |=> !running;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("start-up left with clear low"); // see R20

  property p_chain_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
      frame_done && cmd == odurc_pkg::CMD_CHAIN |=> chain_r == $past(data[0]);
  endproperty
  a_chain_bit: assert property (p_chain_bit) else $error("chain bit not written"); // see R23
endmodule
`default_nettype wire

// [testbench/odurc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module odurc_host_model (
  // Link pins
  output logic      o_sclk,
  output logic      o_sync_n,
  output logic      o_sdi,
  // Data returned by the device
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  initial begin
    // Clock idles high and stands still between frames
    o_sclk   = 1'b1;
    o_sync_n = 1'b1;
    o_sdi    = 1'b0;
  end

  // One framed 24-bit transfer, MSB first; returns the bits seen on the data output
  task automatic xfer(input logic [23:0] w, output logic [23:0] rx, output logic oe_seen);
    // Step off the system clock edges so the link keeps its own phase
    #1;
    oe_seen  = 1'b0;
    o_sync_n = 1'b0;
    for (int k = 0; k < 24; k++) begin
      o_sdi = w[23-k];
      // Output moves on the rising edge; take it at the falling edge as a host does
      #40 rx[23-k] = i_sdo;
      oe_seen = oe_seen | i_sdo_oe;
      o_sclk  = 1'b0;
      #40 o_sclk = 1'b1;
    end
    #40 o_sync_n = 1'b1;
    // A released data line must not keep showing the last bit
    o_sdi = ~o_sdi;
    #40;
  endtask
endmodule
`default_nettype wire

// [testbench/odurc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module odurc_top_tb;
  logic                                         i_clk;
  logic                                         i_sys_rst;
  logic                                         i_load_strobe_n;
  logic                                         i_clear_n;
  logic                                         i_clear_level_select;
  logic                                         sclk;
  logic                                         sync_n;
  logic                                         sdi;
  logic                                         o_sdo;
  logic                                         o_sdo_oe;
  logic                                         o_sdo_keep;
  logic                                         o_chain_enable;
  logic                                         o_init_done;
  logic [odurc_pkg::NCH-1:0][odurc_pkg::DW-1:0] o_dac_code;
  logic [odurc_pkg::NCH-1:0][odurc_pkg::DW-1:0] o_input_code;
  logic [odurc_pkg::NCH-1:0][1:0]               o_power_mode;
  logic [odurc_pkg::NCH-1:0]                    o_update_mask;
  logic [15:0]                                  exp_in [8];
  logic [15:0]                                  exp_dac [8];
  logic [23:0]                                  rx;
  logic                                         oe_seen;
  logic [15:0]                                  d;
  logic [15:0]                                  pw;
  logic [7:0]                                   mask;
  logic [2:0]                                   ch;
  int                                           seed = 18482;
  int                                           miscompares = 0;
  int                                           samples_checked = 0;

  odurc_top dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdi(sdi),
    .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_sdo_keep(o_sdo_keep),
    .i_load_strobe_n(i_load_strobe_n), .i_clear_n(i_clear_n),
    .i_clear_level_select(i_clear_level_select), .o_dac_code(o_dac_code),
    .o_input_code(o_input_code), .o_power_mode(o_power_mode),
    .o_update_mask(o_update_mask), .o_chain_enable(o_chain_enable),
    .o_init_done(o_init_done)
  );

  odurc_host_model host_u (
    .o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe)
  );

  initial begin
    i_clk = 1'b0;
  end
  always #2 i_clk = ~i_clk;

  function automatic logic [15:0] f_clr(input logic sel);
    return sel ? odurc_pkg::CODE_MID : odurc_pkg::CODE_ZERO;
  endfunction

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Frame plus margin for the crossing and execution
  task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] v);
    host_u.xfer({c, a, v}, rx, oe_seen);
    cyc(8);
  endtask

  task automatic chk_regs;
    for (int n = 0; n < 8; n++) begin
      chk(o_input_code[n], exp_in[n]);
      chk(o_dac_code[n], exp_dac[n]);
    end
  endtask

  task automatic strobe_pulse;
    i_load_strobe_n <= 1'b0;
    cyc(5);
    i_load_strobe_n <= 1'b1;
    cyc(5);
  endtask

  initial begin
    #200000;
    miscompares++;
    stop_test;
  end

  initial begin
    i_sys_rst            = 1'b1;
    i_load_strobe_n      = 1'b1;
    i_clear_n            = 1'b1;
    i_clear_level_select = 1'b0;
    cyc(2);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 50 && o_init_done !== 1'b1; i++) cyc(1);
    chk(16'(o_init_done), 16'h0001);
    chk(16'(o_update_mask), 16'h0000);
    chk(16'(o_chain_enable), 16'h0000);
    for (int n = 0; n < 8; n++) chk(16'(o_power_mode[n]), 16'h0000);
    for (int n = 0; n < 8; n++) begin
      exp_in[n]  = f_clr(1'b0);
      exp_dac[n] = f_clr(1'b0);
    end
    chk_regs;
    for (int i = 0; i < 6; i++) begin
      ch = 3'($random(seed));
      d  = 16'($random(seed));
      frame(odurc_pkg::CMD_WR_UPD, {1'b0, ch}, d);
      exp_in[ch]  = d;
      exp_dac[ch] = d;
    end
    chk_regs;
    // Mask with both end channels as corners; upper data and address ignored
    mask    = 8'($random(seed));
    mask[0] = 1'b0;
    mask[7] = 1'b1;
    frame(odurc_pkg::CMD_MASK, 4'hF, {8'($random(seed)), mask});
    chk(16'(o_update_mask), {8'h00, mask});
    for (int n = 0; n < 8; n++) begin
      d = 16'($random(seed));
      frame(odurc_pkg::CMD_WR_IN, 4'(n), d);
      exp_in[n] = d;
    end
    chk_regs;
    strobe_pulse;
    for (int n = 0; n < 8; n++) if (!mask[n]) exp_dac[n] = exp_in[n];
    chk_regs;
    // Strobe held low reaches a masked channel as well
    i_load_strobe_n <= 1'b0;
    cyc(5);
    d = 16'($random(seed));
    frame(odurc_pkg::CMD_WR_IN, 4'h7, d);
    exp_in[7]  = d;
    exp_dac[7] = d;
    chk_regs;
    i_load_strobe_n <= 1'b1;
    cyc(5);
    frame(odurc_pkg::CMD_WR_IN, 4'h2, 16'hFFFF);
    frame(odurc_pkg::CMD_WR_IN, 4'h3, 16'h0001);
    exp_in[2] = 16'hFFFF;
    exp_in[3] = 16'h0001;
    frame(odurc_pkg::CMD_UPD, 4'h0, 16'h0024);
    exp_dac[2] = exp_in[2];
    exp_dac[5] = exp_in[5];
    chk_regs;
    pw      = 16'($random(seed));
    pw[1:0] = odurc_pkg::PWR_TRI;
    pw[3:2] = odurc_pkg::PWR_GND;
    pw[5:4] = odurc_pkg::PWR_NORMAL;
    frame(odurc_pkg::CMD_PWR, {1'b0, 3'($random(seed))}, pw);
    for (int n = 0; n < 8; n++) chk(16'(o_power_mode[n]), 16'(pw[2*n +: 2]));
    chk_regs;
    d = 16'($random(seed));
    frame(odurc_pkg::CMD_WR_UPD, 4'h0, d);
    exp_in[0]  = d;
    exp_dac[0] = d;
    chk_regs;
    for (int i = 0; i < 3; i++) begin
      ch = (i == 0) ? 3'h7 : 3'($random(seed));
      frame(odurc_pkg::CMD_READ, {1'b0, ch}, 16'($random(seed)));
      frame(odurc_pkg::CMD_NOP, 4'h0, 16'h0000);
      chk(rx[15:0], exp_dac[ch]);
      chk(16'(oe_seen), 16'h0001);
      chk(16'(o_sdo_oe), 16'h0000);
      chk(16'(o_sdo), 16'(exp_dac[ch][0]));
      chk(16'(o_sdo_keep), 16'h0001);
    end
    frame(odurc_pkg::CMD_NOP, 4'h0, 16'h0000);
    chk(16'(oe_seen), 16'h0000);
    frame(odurc_pkg::CMD_CHAIN, 4'h0, 16'h0001);
    chk(16'(o_chain_enable), 16'h0001);
    frame(odurc_pkg::CMD_READ, 4'h3, 16'h0000);
    frame(4'hF, 4'h0, 16'h0000);
    chk(rx[15:0], exp_dac[3]);
    frame(odurc_pkg::CMD_CHAIN, 4'h0, 16'h0000);
    chk(16'(o_chain_enable), 16'h0000);
    i_clear_level_select <= 1'b1;
    i_clear_n            <= 1'b0;
    cyc(6);
    for (int n = 0; n < 8; n++) begin
      exp_in[n]  = f_clr(1'b1);
      exp_dac[n] = f_clr(1'b1);
    end
    chk_regs;
    frame(odurc_pkg::CMD_WR_UPD, 4'h1, 16'h1234);
    strobe_pulse;
    chk_regs;
    i_clear_n <= 1'b1;
    cyc(6);
    chk_regs;
    frame(odurc_pkg::CMD_WR_IN, 4'h4, 16'h00FF);
    exp_in[4] = 16'h00FF;
    chk_regs;
    d = 16'($random(seed));
    frame(odurc_pkg::CMD_WR_IN_ALL, 4'h0, d);
    for (int n = 0; n < 8; n++) exp_in[n] = d;
    chk_regs;
    d = 16'($random(seed));
    frame(odurc_pkg::CMD_WR_UPD_ALL, 4'h0, d);
    for (int n = 0; n < 8; n++) begin
      exp_in[n]  = d;
      exp_dac[n] = d;
    end
    chk_regs;
    stop_test;
  end
endmodule
`default_nettype wire
